// ### hw/ttu_regs.vh
`ifndef TTU_REGS_VH
`define TTU_REGS_VH
// register byte offsets
`define TTU_OFF_CTRL 8'h00
`define TTU_OFF_OPCODE 8'h04
`define TTU_OFF_EXT 8'h08
`define TTU_OFF_FLAGS 8'h0c
`define TTU_OFF_SSP 8'h10
`define TTU_OFF_PC 8'h14
`define TTU_OFF_STATUS 8'h18
`define TTU_OFF_IRQ 8'h1c
`define TTU_OFF_MASK 8'h20
`define TTU_OFF_AREG 8'h24
`define TTU_OFF_SP 8'h28
`define TTU_OFF_VEC 8'h2c
`define TTU_OFF_OPND 8'h30
// flag byte fields
`define TTU_F_C 0
`define TTU_F_V 1
`define TTU_F_Z 2
`define TTU_F_N 3
`define TTU_F_X 4
// irq bits
`define TTU_IRQ_DONE 0
`define TTU_IRQ_TRAP 1
`define TTU_IRQ_ILL 2
// vectors and constants
`define TTU_VEC_TRAP_BASE 8'h20
`define TTU_VEC_CC 8'h07
`define TTU_VEC_ILL 8'h04
`define TTU_SR_RESET 16'h2700
`define TTU_SSP_RESET 32'h0000_1000
`endif

// ### hw/ttu_core.v
`timescale 1ns/1ps
`include "ttu_regs.vh"
// Operation
// [RULE1] test-and-set takes data-alterable modes only
// [RULE2] test-and-set sets flags, then sets bit 7 atomically
// [RULE3] trap pushes format, pc, status on supervisor stack
// [RULE4] trap vector number is operand plus 32
// [RULE5] trap vector from low opcode nibble, flags kept
// [RULE6] conditional trap true raises vector 7, else continues
// [RULE7] condition field decodes sixteen conditions
// [RULE8] conditions evaluated from n, z, v, c flags
// [RULE9] opmode 010 word, 011 long, 100 none
// [RULE10] immediate words follow opcode, kept for handler
// [RULE11] condition bits 11:8, opmode bits 2:0
// [RULE12] overflow trap raises vector 7 when v set
// [RULE13] test compares with zero, clears v and c
// [RULE14] test size 00 byte, 01 word, 10 long
// [RULE15] test accepts every operand mode
// [RULE16] test of address register needs word or long
// [RULE17] unlink loads sp, pops register, sp plus 4
// [RULE18] disallowed mode raises illegal-instruction exception
module ttu_core (
  input wire clk_i, // clock
  input wire rst_i, // sync reset, active high
  input wire wb_cyc_i, // wishbone cycle
  input wire wb_stb_i, // wishbone strobe
  input wire wb_we_i, // write enable
  input wire [7:0] wb_adr_i, // byte address
  input wire [3:0] wb_sel_i, // byte selects
  input wire [31:0] wb_dat_i, // write data
  output reg [31:0] wb_dat_o, // read data
  output reg wb_ack_o, // acknowledge
  output wire irq_o, // level interrupt
  output reg mem_req_o, // memory request
  output reg mem_we_o, // memory write
  output reg mem_lock_o, // indivisible cycle in progress
  output reg [1:0] mem_size_o, // 0 byte 1 word 2 long
  output reg [31:0] mem_adr_o, // memory address
  output reg [31:0] mem_dat_o, // memory write data
  input wire mem_ack_i, // memory done
  input wire [31:0] mem_dat_i // memory read data
);
  localparam S_IDLE = 3'd0;
  localparam S_DEC = 3'd1;
  localparam S_PUSH = 3'd2;
  localparam S_RD = 3'd3;
  localparam S_WR = 3'd4;
  localparam S_POP = 3'd5;
  localparam S_DONE = 3'd6;

  reg [15:0] opcode;
  reg [31:0] operand;
  reg [4:0] flags;
  reg [15:0] status_word;
  reg [31:0] supervisor_stack_pointer;
  reg [31:0] pc;
  reg [31:0] address_reg_n;
  reg [31:0] stack_ptr;
  reg [7:0] vector;
  reg [2:0] irq_stat;
  reg [2:0] irq_mask;
  reg [2:0] state;
  reg [1:0] push_idx;
  reg busy;
  reg go;

  wire [2:0] ea_mode = opcode[5:3];
  wire [2:0] ea_reg = opcode[2:0];
  wire [1:0] tst_size = opcode[7:6];
  wire is_tas = (opcode[15:6] == 10'h12b);
  wire is_tst = (opcode[15:8] == 8'h4a) && (tst_size != 2'b11);
  wire is_trap = (opcode[15:4] == 12'h4e4);
  wire is_overflow_trap_op = (opcode == 16'h4e76);
  wire is_frame_unlink_op = (opcode[15:3] == 13'h09cb);
  wire is_conditional_trap_op = (opcode[15:12] == 4'h5) && (opcode[7:3] == 5'h1f); // RULE11
  wire [3:0] cond = opcode[11:8]; // RULE11
  wire [2:0] opmode = opcode[2:0]; // RULE11
  wire fn = flags[`TTU_F_N];
  wire fz = flags[`TTU_F_Z];
  wire fv = flags[`TTU_F_V];
  wire fc = flags[`TTU_F_C];

  reg cond_true;
  always @*
  begin
    case (cond) // RULE7 RULE8
      4'h0: cond_true = 1'b1;
      4'h1: cond_true = 1'b0;
      4'h2: cond_true = ~fc & ~fz; // cond_high
      4'h3: cond_true = fc | fz; // cond_low_or_same
      4'h4: cond_true = ~fc;
      4'h5: cond_true = fc;
      4'h6: cond_true = ~fz;
      4'h7: cond_true = fz;
      4'h8: cond_true = ~fv;
      4'h9: cond_true = fv;
      4'ha: cond_true = ~fn;
      4'hb: cond_true = fn;
      4'hc: cond_true = (fn == fv); // cond_greater_or_equal
      4'hd: cond_true = (fn != fv); // cond_less
      4'he: cond_true = (fn == fv) & ~fz; // cond_greater
      default: cond_true = fz | (fn != fv); // cond_less_or_equal
    endcase
  end

  // legality of operand modes
  wire tas_ok = (ea_mode != 3'b001) && ((ea_mode != 3'b111) || (ea_reg[2:1] == 2'b00)); // RULE1
  wire tst_ok = ((ea_mode != 3'b001) || (tst_size != 2'b00)) // RULE16
    && ((ea_mode != 3'b111) || (ea_reg <= 3'b100)); // RULE15
  wire cc_ok = (opmode == 3'b010) || (opmode == 3'b011) || (opmode == 3'b100); // RULE9
  // instruction length in bytes, immediate words belong to the instruction
  wire [31:0] cc_len = (opmode == 3'b010) ? 32'd4 : (opmode == 3'b011) ? 32'd6 : 32'd2; // RULE9 RULE10

  // test result at operand width
  reg t_neg;
  reg t_zero;
  always @*
  begin
    case (tst_size) // RULE14
      2'b00:
      begin
        t_neg = operand[7];
        t_zero = (operand[7:0] == 8'h00);
      end
      2'b01:
      begin
        t_neg = operand[15];
        t_zero = (operand[15:0] == 16'h0000);
      end
      default:
      begin
        t_neg = operand[31];
        t_zero = (operand == 32'h0);
      end
    endcase
  end

  wire bus_hit = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  wire bus_wr = bus_hit & wb_we_i & (&wb_sel_i);
  wire push_last = (state == S_PUSH) && mem_req_o && mem_ack_i && (push_idx == 2'd2);
  wire push_ill = (vector == `TTU_VEC_ILL);
  wire [2:0] irq_set = {push_last & push_ill, push_last & ~push_ill, state == S_DONE};

  assign irq_o = |(irq_stat & irq_mask);

  // wishbone read mux, one wait cycle
  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0;
    end
    else
    begin
      wb_ack_o <= bus_hit;
      if (bus_hit)
      begin
        case (wb_adr_i)
          `TTU_OFF_CTRL: wb_dat_o <= {31'h0, busy};
          `TTU_OFF_OPCODE: wb_dat_o <= {16'h0, opcode};
          `TTU_OFF_EXT: wb_dat_o <= {16'h0, status_word};
          `TTU_OFF_FLAGS: wb_dat_o <= {27'h0, flags};
          `TTU_OFF_SSP: wb_dat_o <= supervisor_stack_pointer;
          `TTU_OFF_PC: wb_dat_o <= pc;
          `TTU_OFF_STATUS: wb_dat_o <= {29'h0, irq_stat};
          `TTU_OFF_IRQ: wb_dat_o <= {31'h0, irq_o};
          `TTU_OFF_MASK: wb_dat_o <= {29'h0, irq_mask};
          `TTU_OFF_AREG: wb_dat_o <= address_reg_n;
          `TTU_OFF_SP: wb_dat_o <= stack_ptr;
          `TTU_OFF_VEC: wb_dat_o <= {24'h0, vector};
          `TTU_OFF_OPND: wb_dat_o <= operand;
          default: wb_dat_o <= 32'h0;
        endcase
      end
    end
  end

  // execution sequencer
  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      state <= S_IDLE;
      opcode <= 16'h0;
      operand <= 32'h0;
      flags <= 5'h0;
      status_word <= `TTU_SR_RESET;
      supervisor_stack_pointer <= `TTU_SSP_RESET;
      pc <= 32'h0;
      address_reg_n <= 32'h0;
      stack_ptr <= 32'h0;
      vector <= 8'h0;
      irq_stat <= 3'h0;
      irq_mask <= 3'h0;
      push_idx <= 2'd0;
      busy <= 1'b0;
      go <= 1'b0;
      mem_req_o <= 1'b0;
      mem_we_o <= 1'b0;
      mem_lock_o <= 1'b0;
      mem_size_o <= 2'd0;
      mem_adr_o <= 32'h0;
      mem_dat_o <= 32'h0;
    end
    else
    begin
      go <= 1'b0;
      if (bus_wr && !busy)
      begin
        case (wb_adr_i)
          `TTU_OFF_CTRL: go <= wb_dat_i[0];
          `TTU_OFF_OPCODE: opcode <= wb_dat_i[15:0];
          `TTU_OFF_EXT: status_word <= wb_dat_i[15:0];
          `TTU_OFF_FLAGS: flags <= wb_dat_i[4:0];
          `TTU_OFF_SSP: supervisor_stack_pointer <= wb_dat_i;
          `TTU_OFF_PC: pc <= wb_dat_i;
          `TTU_OFF_AREG: address_reg_n <= wb_dat_i;
          `TTU_OFF_SP: stack_ptr <= wb_dat_i;
          `TTU_OFF_OPND: operand <= wb_dat_i;
          default: ;
        endcase
      end
      if (bus_wr && wb_adr_i == `TTU_OFF_MASK)
        irq_mask <= wb_dat_i[2:0];
      case (state)
        S_IDLE:
        begin
          if (go)
          begin
            busy <= 1'b1;
            state <= S_DEC;
          end
        end
        S_DEC:
        begin
          state <= S_DONE;
          if (is_trap)
          begin
            vector <= `TTU_VEC_TRAP_BASE + {4'h0, opcode[3:0]}; // RULE4 RULE5
            pc <= pc + 32'd2;
            state <= S_PUSH;
          end
          else if (is_overflow_trap_op)
          begin
            pc <= pc + 32'd2;
            if (fv) // RULE12
            begin
              vector <= `TTU_VEC_CC;
              state <= S_PUSH;
            end
          end
          else if (is_conditional_trap_op && cc_ok)
          begin
            pc <= pc + cc_len; // RULE10
            if (cond_true) // RULE6
            begin
              vector <= `TTU_VEC_CC;
              state <= S_PUSH;
            end
          end
          else if (is_tst && tst_ok)
          begin
            pc <= pc + 32'd2;
            flags[`TTU_F_N] <= t_neg; // RULE13
            flags[`TTU_F_Z] <= t_zero;
            flags[`TTU_F_V] <= 1'b0;
            flags[`TTU_F_C] <= 1'b0;
          end
          else if (is_tas && tas_ok)
          begin
            pc <= pc + 32'd2;
            if (ea_mode == 3'b000)
            begin
              flags[`TTU_F_N] <= operand[7]; // RULE2
              flags[`TTU_F_Z] <= (operand[7:0] == 8'h00);
              flags[`TTU_F_V] <= 1'b0;
              flags[`TTU_F_C] <= 1'b0;
              operand <= operand | 32'h80;
            end
            else
            begin
              // operand holds the effective address; bus stays locked read to write
              mem_adr_o <= operand;
              mem_size_o <= 2'd0;
              mem_we_o <= 1'b0;
              mem_lock_o <= 1'b1; // RULE2
              mem_req_o <= 1'b1;
              state <= S_RD;
            end
          end
          else if (is_frame_unlink_op)
          begin
            stack_ptr <= address_reg_n; // RULE17
            mem_adr_o <= address_reg_n;
            mem_size_o <= 2'd2;
            mem_we_o <= 1'b0;
            mem_req_o <= 1'b1;
            pc <= pc + 32'd2;
            state <= S_POP;
          end
          else
          begin
            vector <= `TTU_VEC_ILL; // RULE18
            state <= S_PUSH;
          end
          push_idx <= 2'd0;
        end
        S_PUSH:
        begin
          if (!mem_req_o)
          begin
            mem_req_o <= 1'b1;
            mem_we_o <= 1'b1;
            case (push_idx) // RULE3
              2'd0:
              begin
                mem_adr_o <= supervisor_stack_pointer - 32'd2;
                mem_size_o <= 2'd1;
                mem_dat_o <= {16'h0, 4'h0, 2'b00, vector, 2'b00};
                supervisor_stack_pointer <= supervisor_stack_pointer - 32'd2;
              end
              2'd1:
              begin
                mem_adr_o <= supervisor_stack_pointer - 32'd4;
                mem_size_o <= 2'd2;
                mem_dat_o <= pc;
                supervisor_stack_pointer <= supervisor_stack_pointer - 32'd4;
              end
              default:
              begin
                mem_adr_o <= supervisor_stack_pointer - 32'd2;
                mem_size_o <= 2'd1;
                mem_dat_o <= {16'h0, status_word};
                supervisor_stack_pointer <= supervisor_stack_pointer - 32'd2;
              end
            endcase
          end
          else if (mem_ack_i)
          begin
            mem_req_o <= 1'b0;
            mem_we_o <= 1'b0;
            if (push_idx == 2'd2)
            begin
              pc <= {22'h0, vector, 2'b00}; // RULE3
              state <= S_DONE;
            end
            push_idx <= push_idx + 2'd1;
          end
        end
        S_RD:
        begin
          if (mem_ack_i)
          begin
            flags[`TTU_F_N] <= mem_dat_i[7]; // RULE2
            flags[`TTU_F_Z] <= (mem_dat_i[7:0] == 8'h00);
            flags[`TTU_F_V] <= 1'b0;
            flags[`TTU_F_C] <= 1'b0;
            mem_we_o <= 1'b1;
            mem_dat_o <= {24'h0, mem_dat_i[7:0] | 8'h80}; // RULE2
            state <= S_WR;
          end
        end
        S_WR:
        begin
          if (mem_ack_i)
          begin
            mem_req_o <= 1'b0;
            mem_we_o <= 1'b0;
            mem_lock_o <= 1'b0;
            state <= S_DONE;
          end
        end
        S_POP:
        begin
          if (mem_ack_i)
          begin
            mem_req_o <= 1'b0;
            address_reg_n <= mem_dat_i; // RULE17
            stack_ptr <= stack_ptr + 32'd4;
            state <= S_DONE;
          end
        end
        S_DONE:
        begin
          busy <= 1'b0;
          state <= S_IDLE;
        end
        default: state <= S_IDLE;
      endcase
      // set wins over write-one-to-clear
      if (bus_wr && wb_adr_i == `TTU_OFF_STATUS)
        irq_stat <= (irq_stat & ~wb_dat_i[2:0]) | irq_set;
      else
        irq_stat <= irq_stat | irq_set;
    end
  end
endmodule // ttu_core

// ### tb/ttu_props.sv
`timescale 1ns/1ps
module ttu_props (
  input wire clk_i, // clock
  input wire rst_i, // reset
  input wire wb_cyc_i, // cycle
  input wire wb_stb_i, // strobe
  input wire wb_ack_o, // ack
  input wire mem_req_o, // request
  input wire mem_we_o, // write
  input wire mem_lock_o, // lock
  input wire [1:0] mem_size_o, // size
  input wire [31:0] mem_adr_o, // address
  input wire [31:0] mem_dat_o, // write data
  input wire mem_ack_i // done
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  property p_ack_next; wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o; endproperty
  a_ack_next: assert property (p_ack_next) else $error("ack late");
  property p_ack_once; wb_ack_o |=> !wb_ack_o; endproperty
  a_ack_once: assert property (p_ack_once) else $error("ack too long");
  property p_ack_idle; !(wb_cyc_i && wb_stb_i) |=> !wb_ack_o; endproperty
  a_ack_idle: assert property (p_ack_idle) else $error("ack without request");
  property p_req_hold; mem_req_o && !mem_ack_i |=> mem_req_o && $stable(mem_adr_o) && $stable(mem_we_o)
    && $stable(mem_dat_o); endproperty
  a_req_hold: assert property (p_req_hold) else $error("memory request changed");
  property p_rmw; mem_lock_o && mem_req_o && !mem_we_o && mem_ack_i |=> mem_lock_o && mem_req_o && mem_we_o
    && mem_dat_o[7] && $stable(mem_adr_o); endproperty
  a_rmw: assert property (p_rmw) else $error("rmw write wrong");
  property p_rmw_byte; mem_lock_o && mem_req_o |-> mem_size_o == 2'd0; endproperty
  a_rmw_byte: assert property (p_rmw_byte) else $error("rmw not byte");
  property p_push_gap; mem_we_o && mem_ack_i && !mem_lock_o |=> !mem_req_o; endproperty
  a_push_gap: assert property (p_push_gap) else $error("no gap after push");
  property p_push_pc; mem_ack_i && mem_we_o && !mem_lock_o && mem_size_o == 2'd1 ##2 mem_req_o && mem_we_o
    |-> mem_size_o == 2'd2 && mem_adr_o == $past(mem_adr_o, 2) - 32'd4; endproperty
  a_push_pc: assert property (p_push_pc) else $error("pc push wrong");
  property p_push_sr; mem_ack_i && mem_we_o && mem_size_o == 2'd2 ##2 mem_req_o
    |-> mem_we_o && mem_size_o == 2'd1 && mem_adr_o == $past(mem_adr_o, 2) - 32'd2; endproperty
  a_push_sr: assert property (p_push_sr) else $error("status push wrong");
  c_rmw: cover property (mem_lock_o && mem_we_o && mem_ack_i);
  c_push: cover property (mem_we_o && mem_size_o == 2'd2 && mem_ack_i);
  c_pop: cover property (mem_req_o && !mem_we_o && mem_size_o == 2'd2 && mem_ack_i);
endmodule // ttu_props

// ### tb/ttu_mem_model.sv
`timescale 1ns/1ps
module ttu_mem_model (
  input wire clk_i, // clock
  input wire rst_i, // reset
  input wire req_i, // request
  input wire we_i, // write
  input wire [31:0] adr_i, // address
  input wire [31:0] dat_i, // write data
  input wire [1:0] dly_i, // wait cycles
  input wire [31:0] rdat_i, // read value
  output reg ack_o = 1'b0, // done
  output reg [31:0] dat_o = 32'h0 // read data
);
  reg [1:0] cnt = 2'd0;
  reg [31:0] wa [0:7];
  reg [31:0] wd [0:7];
  reg [31:0] ra;
  integer wn = 0, rn = 0;
  wire go = req_i && !rst_i && !ack_o && cnt >= dly_i;
  always @(posedge clk_i)
  begin
    ack_o <= go;
    // data toggles outside an answer so stale values never match
    dat_o <= (go && !we_i) ? rdat_i : ~dat_o;
    if (rst_i || ack_o)
      cnt <= 2'd0;
    else if (req_i && cnt < dly_i)
      cnt <= cnt + 2'd1;
    if (go && we_i)
    begin
      wa[wn % 8] = adr_i;
      wd[wn % 8] = dat_i;
      wn = wn + 1;
    end
    if (go && !we_i)
    begin
      ra = adr_i;
      rn = rn + 1;
    end
  end
endmodule // ttu_mem_model

// ### tb/tb.sv
`timescale 1ns/1ps
module tb;
  reg clk_i = 1'b0;
  reg rst_i = 1'b1;
  reg cyc = 1'b0;
  reg stb = 1'b0;
  reg wwe = 1'b0;
  reg [7:0] adr = 8'h00;
  reg [31:0] wd = 32'h0, mrv = 32'h0, seed = 32'd19820, sp, pc, q, st, op, ln;
  reg [1:0] dly = 2'd0, sz;
  reg [4:0] f;
  reg [2:0] md, rg;
  reg [7:0] b;
  reg t, il;
  integer err_count = 0, checked = 0, i, k;
  wire [31:0] rdat, madr, mwd, mrd;
  wire [1:0] msz;
  wire ack, irq, mreq, mwe, mlk, mack;
  always #5 clk_i = ~clk_i;
  ttu_core i_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(wwe), .wb_adr_i(adr),
    .wb_sel_i(4'hf), .wb_dat_i(wd), .wb_dat_o(rdat), .wb_ack_o(ack), .irq_o(irq), .mem_req_o(mreq),
    .mem_we_o(mwe), .mem_lock_o(mlk), .mem_size_o(msz), .mem_adr_o(madr), .mem_dat_o(mwd),
    .mem_ack_i(mack), .mem_dat_i(mrd));
  ttu_mem_model i_mem (.clk_i(clk_i), .rst_i(rst_i), .req_i(mreq), .we_i(mwe), .adr_i(madr), .dat_i(mwd),
    .dly_i(dly), .rdat_i(mrv), .ack_o(mack), .dat_o(mrd));
  function [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    rnd = seed;
  endfunction
  function cond(input [3:0] c, input [4:0] g);
    reg [15:0] e;
    begin
      e = {g[2] | (g[3] ^ g[1]), !g[2] & !(g[3] ^ g[1]), g[3] ^ g[1], !(g[3] ^ g[1]), g[3], !g[3], g[1], !g[1],
        g[2], !g[2], g[0], !g[0], g[0] | g[2], !g[0] & !g[2], 1'b0, 1'b1};
      cond = e[c];
    end
  endfunction
  task results;
    begin
      $display("checked %0d mismatches %0d", checked, err_count);
      if (err_count == 0 && checked > 0)
        $display("*** PASS ***");
      else
        $display("*** FAIL ***");
      $finish;
    end
  endtask
  task chk(input [31:0] s, input [31:0] e, input string nm);
    begin
      checked = checked + 1;
      if (s !== e)
      begin
        err_count = err_count + 1;
        $display("mismatch %s expected %h seen %h", nm, e, s);
      end
    end
  endtask
  task bus(input w, input [7:0] a, input [31:0] d);
    integer n;
    begin
      @(posedge clk_i);
      cyc <= 1'b1;
      stb <= 1'b1;
      wwe <= w;
      adr <= a;
      wd <= d;
      n = 0;
      @(posedge clk_i);
      while (ack !== 1'b1 && n < 40)
      begin
        @(posedge clk_i);
        n = n + 1;
      end
      if (n >= 40)
      begin
        err_count = err_count + 1;
        results;
      end
      q = rdat;
      cyc <= 1'b0;
      stb <= 1'b0;
    end
  endtask
  task setf;
    begin
      q = rnd();
      f = q[4:0];
      bus(1'b1, 8'h0c, {27'h0, f});
    end
  endtask
  task flk(input [4:0] e);
    begin
      bus(1'b0, 8'h0c, 32'h0);
      chk(q[4:0], e, "flags");
    end
  endtask
  task prep;
    begin
      sp = 32'h2000 + (rnd() & 32'hff0);
      pc = rnd() & 32'hfffe;
      bus(1'b1, 8'h10, sp);
      bus(1'b1, 8'h14, pc);
      setf;
    end
  endtask
  task run(input [15:0] o, input et, input ei);
    integer n;
    reg [31:0] mk;
    begin
      mk = rnd() & 32'h7;
      bus(1'b1, 8'h20, mk);
      i_mem.wn = 0;
      i_mem.rn = 0;
      q = rnd();
      dly <= q[1:0];
      bus(1'b1, 8'h04, {16'h0, o});
      bus(1'b1, 8'h00, 32'h1);
      n = 0;
      st = 32'h0;
      while ((st[0] !== 1'b1 || q[0] !== 1'b0) && n < 60)
      begin
        bus(1'b0, 8'h18, 32'h0);
        st = q;
        bus(1'b0, 8'h00, 32'h0);
        n = n + 1;
      end
      if (n >= 60)
      begin
        err_count = err_count + 1;
        results;
      end
      chk(st[1], et, "trap bit");
      chk(st[2], ei, "illegal bit");
      chk(irq, |(st[2:0] & mk[2:0]), "irq");
      bus(1'b1, 8'h18, st);
      bus(1'b0, 8'h18, 32'h0);
      chk(q, 32'h0, "status clear");
      chk(irq, 1'b0, "irq clear");
    end
  endtask
  task frame(input [7:0] v, input [31:0] rp);
    begin
      chk(i_mem.wn, 3, "pushes");
      chk(i_mem.wa[0], sp - 2, "fmt adr");
      chk(i_mem.wd[0][15:0], {6'h0, v, 2'b0}, "fmt");
      chk(i_mem.wa[1], sp - 6, "pc adr");
      chk(i_mem.wd[1], rp, "pc");
      chk(i_mem.wa[2], sp - 8, "sr adr");
      chk(i_mem.wd[2][15:0], 16'h2700, "sr");
      bus(1'b0, 8'h10, 32'h0);
      chk(q, sp - 8, "ssp");
      bus(1'b0, 8'h14, 32'h0);
      chk(q, {22'h0, v, 2'b0}, "vec pc");
    end
  endtask
  initial
  begin
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    for (i = 0; i < 16; i = i + 1)
    begin
      prep;
      run(16'h4e40 | i[15:0], 1'b1, 1'b0);
      frame(8'd32 + i[7:0], pc + 2);
      flk(f);
    end
    $display("trap test end");
    for (i = 0; i < 36; i = i + 1)
    begin
      prep;
      if (i >= 32)
        f = {f[4:2], i[0], f[0]};
      bus(1'b1, 8'h0c, {27'h0, f});
      k = rnd() % 3;
      ln = (k == 2) ? 32'd2 : 32'd4 + 2 * k;
      t = (i >= 32) ? i[0] : cond(i[3:0], f);
      if (i >= 32)
        run(16'h4e76, t, 1'b0);
      else
        run(16'h50f8 | {4'h0, i[3:0], 8'h0} | (16'd2 + k[15:0]), t, 1'b0);
      if (i >= 32)
        ln = 32'd2;
      if (t)
        frame(8'd7, pc + ln);
      else
      begin
        chk(i_mem.wn, 0, "no push");
        bus(1'b0, 8'h14, 32'h0);
        chk(q, pc + ln, "next pc");
      end
      flk(f);
    end
    $display("conditional trap test end");
    for (i = 0; i < 48; i = i + 1)
    begin
      q = rnd();
      md = q[2:0];
      rg = (md == 3'd7 && q[5:3] > 3'd4) ? q[5:3] - 3'd4 : q[5:3];
      sz = (q[7:6] == 2'd3) ? 2'd2 : q[7:6];
      if (i % 24 < 2)
        md = 3'd1;
      sz = (i == 0) ? 2'd0 : (i == 1) ? 2'd1 : sz;
      if (i % 24 == 2)
        {md, rg} = 6'o74;
      op = rnd();
      bus(1'b1, 8'h30, op);
      q = rnd();
      mrv <= q;
      setf;
      if (i < 24)
      begin
        il = md == 3'd1 && sz == 2'd0;
        run(16'h4a00 | {8'h0, sz, md, rg}, 1'b0, il);
        flk(il ? f : {f[4], op[(8 << sz) - 1], (op << (32 - (8 << sz))) == 32'h0, 2'b00});
      end
      else
      begin
        il = md == 3'd1 || (md == 3'd7 && rg > 3'd1);
        run(16'h4ac0 | {10'h0, md, rg}, 1'b0, il);
        b = (md == 3'd0) ? op[7:0] : mrv[7:0];
        if (il)
        begin
          chk(i_mem.rn, 0, "no access");
          chk(i_mem.wn, 3, "illegal frame");
          chk(i_mem.wd[0][15:0], 16'h0010, "illegal fmt");
        end
        else if (md == 3'd0)
        begin
          bus(1'b0, 8'h30, 32'h0);
          chk(q[7:0], b | 8'h80, "reg set");
        end
        else
        begin
          chk(i_mem.wa[0], op, "rmw adr");
          chk(i_mem.wd[0][7:0], b | 8'h80, "rmw data");
        end
        flk(il ? f : {f[4], b[7], b == 8'h0, 2'b00});
      end
    end
    $display("test and set test end");
    for (i = 0; i < 8; i = i + 1)
    begin
      op = rnd() & 32'hfffc;
      bus(1'b1, 8'h24, op);
      q = rnd();
      mrv <= q;
      setf;
      run(16'h4e58 | i[15:0], 1'b0, 1'b0);
      bus(1'b0, 8'h28, 32'h0);
      chk(q, op + 4, "sp");
      chk(i_mem.ra, op, "pop adr");
      bus(1'b0, 8'h24, 32'h0);
      chk(q, mrv, "areg");
      flk(f);
    end
    $display("unlink test end");
    results;
  end
endmodule // tb
bind ttu_core ttu_props i_props (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_ack_o(wb_ack_o), .mem_req_o(mem_req_o), .mem_we_o(mem_we_o), .mem_lock_o(mem_lock_o),
  .mem_size_o(mem_size_o), .mem_adr_o(mem_adr_o), .mem_dat_o(mem_dat_o), .mem_ack_i(mem_ack_i));
